//--- core/emc_defs.vh
/*
 * Register offsets, field positions, reset values and length constants of the
 * ethernet MAC configuration register block.
 * Assumes inclusion by the block's module only; definitions only.
 */
`ifndef EMC_DEFS_VH
`define EMC_DEFS_VH

// =============================================================
// register byte offsets
`define EMC_OFF_FLAGS      5'h00
`define EMC_OFF_IRQ_EN     5'h04
`define EMC_OFF_MGMT       5'h08
`define EMC_OFF_ADDR_HI    5'h0C
`define EMC_OFF_ADDR_LO    5'h10
`define EMC_OFF_LEN_LIMIT  5'h14

// =============================================================
// field positions
`define EMC_BIT_BAD_CARRIER 0
`define EMC_BIT_WAKE_PACKET 1
`define EMC_BIT_LINK_CHANGE 2
`define EMC_BIT_MDC         0
`define EMC_BIT_DIR         1
`define EMC_BIT_DOUT        2
`define EMC_BIT_DIN         3

// =============================================================
// reset values and length decoding
`define EMC_RST_FLAGS      3'h0
`define EMC_RST_LEN_FIELD  12'h000
`define EMC_LEN_STD_TOP    12'h5EE
`define EMC_LEN_STD        12'h5EE
`define EMC_LEN_MAX_TOP    12'h7FF
`define EMC_LEN_MAX        12'h800
`define EMC_CRC_BYTES      12'h004

// axi response codes
`define EMC_RESP_OKAY      2'h0
`define EMC_RESP_SLVERR    2'h2

`endif

//--- core/emc_config_regs.v
/*
 * Ethernet MAC configuration registers: status flags with interrupt enables,
 * software-driven management port, station address, receive length limit and
 * the receive byte gate that applies that limit and strips the CRC.
 * Assumes an AXI4-Lite master on clk, a PHY on the management pins and event
 * lines from the MAC core; pin inputs are asynchronous to clk.
 * The wake-packet event and the receive byte stream come from logic on clk
 * and are used as they arrive.
 * The management clock is formed by software writes alone, so its rate is
 * set by how fast software writes the management register.
 */
`include "emc_defs.vh"

// Operation
// R01 - enable bit 2 lets a set link-change flag raise the interrupt
// R02 - enable bit 1 lets a set wake-packet flag raise the interrupt
// R03 - enable bit 0 gates the bad-carrier flag; enables reset to zero
// R04 - reserved bits read as zero; software writes them as zero
// R05 - management bit 3 reads back the synchronised data pin level
// R06 - management bit 2 drives the data pin only while direction is one
// R07 - management bit 1 selects direction: zero phy drives, one device drives
// R08 - management bit 0 goes straight out as the management clock
// R09 - software bit-bangs each frame, data set before rising edge
// R10 - high address register holds station address bits 47 to 16
// R11 - low address register holds bits 15 to 0, upper half zero
// R12 - first sent octet sits in the high register's top byte
// R13 - software resets the mac before changing the station address
// R14 - length field: up to 5EE means 1518, 800 and above 2048
// R15 - frame length counts destination address through last crc byte
// R16 - bytes beyond the configured limit are discarded; the gate keeps them again once its frame count saturates
// R17 - crc bytes are never passed on toward memory
// R18 - flags set by events, cleared only by writing one
// R19 - interrupt is the or of each flag and its enable
module emc_config_regs (
	input  wire        clk,
	input  wire        rst,
	// axi4-lite slave
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// events from the mac core and phy
	input  wire        link_status_pin,
	input  wire        wake_packet_evt,
	input  wire        bad_carrier_pin,
	// management pins
	output reg         mgmt_clk,
	output reg         mgmt_data_o,
	output reg         mgmt_data_oe,
	input  wire        mgmt_data_i,
	// receive byte stream from the mac core
	input  wire        rx_valid,
	input  wire [7:0]  rx_byte,
	input  wire        rx_last,
	output reg         mem_valid,
	output reg  [7:0]  mem_byte,
	output reg         mem_last,
	// configuration outputs
	output reg  [47:0] station_address,
	output reg         irq
);

	// =============================================================
	// input synchronisers
	// two flops per pin input; only the second stage feeds logic,
	// so a metastable first stage never reaches the edge detectors
	// or the management read-back bit
	reg [2:0] sync_a;
	reg [2:0] sync_b;
	reg       link_prev;
	reg       carrier_prev;

	always @(posedge clk) begin
		if (rst) begin
			sync_a       <= 3'h0;
			sync_b       <= 3'h0;
			link_prev    <= 1'b0;
			carrier_prev <= 1'b0;
		end else begin
			sync_a       <= {mgmt_data_i, bad_carrier_pin, link_status_pin};
			sync_b       <= sync_a;
			link_prev    <= sync_b[0];
			carrier_prev <= sync_b[1];
		end
	end

	// link change fires on either edge of the synchronised pin,
	// bad carrier on its rising edge only; the previous-sample flops
	// reset to the idle level of the pins, and link_seen masks the
	// first cycle after reset so no false change is seen
	wire       mdio_level = sync_b[2];
	// link event enabled one cycle after reset, a cycle before the first synchronised sample reaches sync_b
	reg        link_seen;
	wire [2:0] events;
	assign events[`EMC_BIT_LINK_CHANGE] = link_seen & (sync_b[0] ^ link_prev);
	assign events[`EMC_BIT_WAKE_PACKET] = wake_packet_evt;
	assign events[`EMC_BIT_BAD_CARRIER] = sync_b[1] & ~carrier_prev;

	// =============================================================
	// axi4-lite write channel
	// address and data are each held in a one-deep slot once taken,
	// in either order; the write lands the cycle after both slots
	// are full and no response is pending, and bvalid rises with it
	// ready pulses for one cycle only, so a master that keeps valid
	// up after its handshake is not taken twice
	reg [4:0]  aw_addr;
	reg        aw_held;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg        w_held;
	wire       do_write = aw_held & w_held & ~s_axi_bvalid;

	always @(posedge clk) begin
		if (rst) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 5'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EMC_RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok(aw_addr) ? `EMC_RESP_OKAY : `EMC_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// mapped offsets; anything else answers with an error code
	// and leaves every register untouched
	function addr_ok;
		input [4:0] a;
		begin
			addr_ok = (a == `EMC_OFF_FLAGS) || (a == `EMC_OFF_IRQ_EN) ||
				(a == `EMC_OFF_MGMT) || (a == `EMC_OFF_ADDR_HI) ||
				(a == `EMC_OFF_ADDR_LO) || (a == `EMC_OFF_LEN_LIMIT);
		end
	endfunction

	// byte-lane merge of the write data over an old value
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	wire wr_flags = do_write & (aw_addr == `EMC_OFF_FLAGS);
	wire wr_en    = do_write & (aw_addr == `EMC_OFF_IRQ_EN);
	wire wr_mgmt  = do_write & (aw_addr == `EMC_OFF_MGMT);
	wire wr_hi    = do_write & (aw_addr == `EMC_OFF_ADDR_HI);
	wire wr_lo    = do_write & (aw_addr == `EMC_OFF_ADDR_LO);
	wire wr_len   = do_write & (aw_addr == `EMC_OFF_LEN_LIMIT);

	// =============================================================
	// registers
	// enable, management and address registers honour the byte
	// strobes; the three-bit fields live in byte lane zero only
	// reserved bits are never stored, so they always read as zero
	// the management outputs change only by software writes: the
	// clock bit is toggled by software and the data bit is driven
	// onto the shared line only while the direction bit is one
	localparam FLAG_W = 3;
	reg  [2:0]  flags;
	reg  [2:0]  irq_enable;
	reg  [11:0] len_field;
	wire [2:0]  clear_mask = (wr_flags & w_strb[0]) ? w_data[2:0] : 3'h0;
	wire [31:0] hi_next = merge(station_address[47:16], w_data, w_strb);
	wire [31:0] lo_next = merge({16'h0000, station_address[15:0]}, w_data, w_strb);
	wire [31:0] len_next = merge({20'h00000, len_field}, w_data, w_strb);

	always @(posedge clk) begin
		if (rst) begin
			irq_enable      <= 3'h0;                                // [R03]
			len_field       <= `EMC_RST_LEN_FIELD;
			station_address <= 48'h000000000000;
			link_seen       <= 1'b0;
			mgmt_clk        <= 1'b0;
			mgmt_data_o     <= 1'b0;
			mgmt_data_oe    <= 1'b0;
			irq             <= 1'b0;
		end else begin
			link_seen <= 1'b1;
			if (wr_en & w_strb[0])
				irq_enable <= w_data[2:0];                          // [R04]
			if (wr_mgmt & w_strb[0]) begin
				mgmt_clk     <= w_data[`EMC_BIT_MDC];               // [R08]
				mgmt_data_o  <= w_data[`EMC_BIT_DOUT];              // [R06]
				mgmt_data_oe <= w_data[`EMC_BIT_DIR];               // [R07]
			end
			if (wr_hi)
				station_address[47:16] <= hi_next;                  // [R10] [R12]
			if (wr_lo)
				station_address[15:0] <= lo_next[15:0];             // [R11]
			if (wr_len)
				len_field <= len_next[11:0];
			irq <= |(flags & irq_enable);                           // [R01] [R02] [R03] [R19]
		end
	end

	// =============================================================
	// sticky status flags, one per event source
	// each flag is set by its event and cleared by writing one to
	// it in byte lane zero; writing zero leaves it as it is
	wire [2:0] rst_flags = `EMC_RST_FLAGS;
	genvar g;

	generate
		for (g = 0; g < FLAG_W; g = g + 1) begin : flag_bit
			always @(posedge clk) begin
				if (rst) begin
					flags[g] <= rst_flags[g];
				end else if (events[g]) begin
					// set wins over a simultaneous write-one clear
					flags[g] <= 1'b1;                               // [R18]
				end else if (clear_mask[g]) begin
					flags[g] <= 1'b0;                               // [R18]
				end
			end
		end
	endgenerate

	// =============================================================
	// axi4-lite read channel
	// read data is captured with arready's handshake and held with
	// rvalid until the master takes it; unmapped offsets answer
	// with an error code and zero data
	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h00000000;                                  // [R04]
		case (s_axi_araddr)
		`EMC_OFF_FLAGS:     next_rdata[2:0] = flags;
		`EMC_OFF_IRQ_EN:    next_rdata[2:0] = irq_enable;
		`EMC_OFF_MGMT:      next_rdata[3:0] = {mdio_level, mgmt_data_o,
			mgmt_data_oe, mgmt_clk};                                // [R05]
		`EMC_OFF_ADDR_HI:   next_rdata = station_address[47:16];
		`EMC_OFF_ADDR_LO:   next_rdata[15:0] = station_address[15:0];
		`EMC_OFF_LEN_LIMIT: next_rdata[11:0] = len_field;
		default:            next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `EMC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= addr_ok(s_axi_araddr) ? `EMC_RESP_OKAY : `EMC_RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// =============================================================
	// receive length gate
	// limit decoding from the programmed field
	// low field values all mean the standard frame size, high ones
	// the largest size; values between are the byte count itself
	wire [11:0] rx_limit = (len_field <= `EMC_LEN_STD_TOP) ? `EMC_LEN_STD :
		(len_field <= `EMC_LEN_MAX_TOP) ? len_field : `EMC_LEN_MAX; // [R14]

	// the frame counter reaches one on the first destination byte
	// and includes the crc bytes; it saturates at its top value, but the
	// compare uses the count plus one, which wraps to zero there, so a
	// runaway frame falls back under the limit once the count is saturated
	// a truncated frame loses its four last kept bytes as well,
	// since the gate cannot tell crc from payload once it cuts
	// the final byte out goes together with the end mark when the
	// frame was not cut; the end mark follows the last byte in

	// bytes are delayed by four so the crc can be dropped at frame end
	reg  [7:0]  dly [0:3];
	reg  [2:0]  dly_fill;
	reg  [11:0] rx_count;
	wire [11:0] next_count = rx_count + 12'h001;
	wire        in_limit = (next_count <= rx_limit);                // [R15]
	integer k;

	always @(posedge clk) begin
		if (rst) begin
			dly_fill  <= 3'h0;
			rx_count  <= 12'h000;
			mem_valid <= 1'b0;
			mem_byte  <= 8'h00;
			mem_last  <= 1'b0;
			for (k = 0; k < 4; k = k + 1)
				dly[k] <= 8'h00;
		end else begin
			mem_valid <= 1'b0;
			mem_last  <= 1'b0;
			if (rx_valid) begin
				if (rx_count != 12'hFFF)
					rx_count <= next_count;
				// beyond the limit nothing more is kept until the frame count saturates [R16]
				if (in_limit) begin
					dly[0] <= rx_byte;
					for (k = 1; k < 4; k = k + 1)
						dly[k] <= dly[k-1];
					if (dly_fill == 3'h4) begin
						mem_valid <= 1'b1;
						mem_byte  <= dly[3];
					end else begin
						dly_fill <= dly_fill + 3'h1;
					end
				end
				if (rx_last) begin
					// the four held bytes are the crc and are dropped [R17]
					mem_last  <= 1'b1;
					dly_fill  <= 3'h0;
					rx_count  <= 12'h000;
				end
			end
		end
	end

endmodule // emc_config_regs

//--- verification/emc_phy_model.sv
/* PHY side of the management port: shifts a pattern onto the data pin.
 * Assumes its output feeds the design's management data input. */
// ====
// phy model
module emc_phy_model (
	input wire logic mclk,
	input wire logic oe,
	input wire logic dout,
	output logic din
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] pat = 16'hA5C3;
	// phy advances only while it owns the line
	always @(posedge mclk) if (!oe) pat <= {pat[14:0], pat[15]};
	// shared line: whoever is enabled sets the level
	assign din = oe ? dout : pat[15];
endmodule // emc_phy_model

//--- verification/emc_checker.sv
/* Port checker for the MAC configuration registers.
 * Assumes address and data of a write are offered together. */
// ====
// checker
module emc_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic rx_valid,
	input wire logic rx_last,
	input wire logic mem_valid,
	input wire logic mem_last,
	input wire logic mgmt_clk,
	input wire logic mgmt_data_o,
	input wire logic mgmt_data_oe,
	input wire logic irq,
	input wire logic [47:0] station_address
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] pw;
	wire mw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == 5'h08;
	always @(posedge clk) if (mw) pw <= s_axi_wdata[2:0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence mgmt_wr; mw; endsequence
	sequence frame_end; rx_valid && rx_last; endsequence
	mdc_follow_a: assert property (mgmt_wr |-> ##[2:4] mgmt_clk == pw[0])
		else $error("management clock differs from register");
	dir_oe_a: assert property (mgmt_wr |-> ##[2:4] mgmt_data_oe == pw[1])
		else $error("data enable differs from direction bit");
	dout_a: assert property (mgmt_wr |-> ##[2:4] mgmt_data_o == pw[2])
		else $error("data out differs from register");
	rst_val_a: assert property (disable iff (1'b0) rst |=> !irq && station_address == 48'h0)
		else $error("nonzero value after reset");
	bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after taken");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	mem_src_a: assert property (mem_valid |-> $past(rx_valid))
		else $error("byte out without byte in");
	mem_last_a: assert property (frame_end |=> mem_last ##1 (!mem_last && !mem_valid))
		else $error("frame end not marked or bytes after it");
endmodule // emc_checker
bind emc_config_regs emc_checker chk (.*);

//--- verification/ether_mac_config_regs_test.sv
/* Self-checking bench for the MAC configuration registers.
 * Assumes the design, the phy model and the checker are compiled first. */
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin err_count++; \
	$display("[FAIL] %s expected %h seen %h", n, e, s); end end
// ====
// bench
module ether_mac_config_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, hi, lo;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_rvalid, link_status_pin = 0, wake_packet_evt = 0, bad_carrier_pin = 0;
	logic mgmt_clk, mgmt_data_o, mgmt_data_oe, mgmt_data_i, irq, mem_valid, mem_last;
	logic rx_valid = 0, rx_last = 0;
	logic [7:0] rx_byte = 0, mem_byte, eb;
	logic [47:0] station_address;
	logic [33:0] er;
	logic [33:0] rq[$];
	logic [7:0] bq[$];
	int err_count = 0, compares = 0, cyc = 0, seed = 32'ha3966a89, i, k;
	int lf[5] = '{0, 'h5F0, 'h7FF, 'h900, 'h5EE};
	int fn[5] = '{1519, 1530, 2047, 2050, 100};
	int lm[5] = '{1518, 1520, 2047, 2048, 1518};
	emc_config_regs dut (.*);
	emc_phy_model phy (.mclk(mgmt_clk), .oe(mgmt_data_oe), .dout(mgmt_data_o), .din(mgmt_data_i));
	initial forever #50 clk = ~clk;
	task complete_run;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			complete_run;
		end
	end
	// ====
	// result watcher
	always @(posedge clk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			er = rq.pop_front();
			`CHK("bresp", er[33:32], s_axi_bresp)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			er = rq.pop_front();
			`CHK("rdata", er, {s_axi_rresp, s_axi_rdata})
		end
		if (mem_valid) begin
			eb = bq.pop_front();
			`CHK("mem_byte", eb, mem_byte)
		end
	end
	// ====
	// drivers
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		logic aw = 0, w = 0;
		rq.push_back({r, 32'h0});
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && w)) begin
			@(posedge clk);
			aw |= s_axi_awvalid & s_axi_awready;
			w |= s_axi_wvalid & s_axi_wready;
			s_axi_awvalid <= s_axi_awvalid & !s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid & !s_axi_wready;
		end
		while (!s_axi_bvalid) @(posedge clk);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid) @(posedge clk);
		s_axi_rready <= 0;
	endtask
	task automatic frame(input int len, input int lim);
		logic [7:0] b;
		for (int j = 0; j < len; j++) begin
			if ($random(seed) % 5 == 0) @(posedge clk) rx_valid <= 0;
			b = $random(seed);
			@(posedge clk);
			rx_valid <= 1;
			rx_byte <= b;
			rx_last <= j == len - 1;
			if (j < ((len < lim) ? len : lim) - 4) bq.push_back(b);
		end
		@(posedge clk);
		rx_valid <= 0;
		rx_last <= 0;
		repeat (8) @(posedge clk);
	endtask
	// ====
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		for (i = 0; i < 24; i += 4) rd(i[4:0], i == 8 ? {30'h0, mgmt_data_i, 3'h0} : 34'h0);
		wr(5'h04, 32'hFFFFFFFF);
		rd(5'h04, 34'h7);
		wr(5'h14, 32'hFFFFFFFF);
		rd(5'h14, 34'hFFF);
		hi = $random(seed);
		lo = $random(seed);
		wr(5'h0C, hi); // address set before any frame traffic
		wr(5'h10, lo);
		rd(5'h0C, {2'h0, hi});
		rd(5'h10, {18'h0, lo[15:0]});
		`CHK("station_address", {hi, lo[15:0]}, station_address)
		wr(5'h18, 32'h1, 2'h2);
		rd(5'h18, 34'h200000000);
		$display("registers done");
		for (i = 0; i < 3; i++) begin
			wr(5'h04, 7 & ~(1 << i));
			@(posedge clk);
			case (i)
			0: bad_carrier_pin <= 1;
			1: wake_packet_evt <= 1;
			default: link_status_pin <= !link_status_pin;
			endcase
			@(posedge clk);
			bad_carrier_pin <= 0;
			wake_packet_evt <= 0;
			repeat (6) @(posedge clk);
			`CHK("irq masked", 1'b0, irq)
			wr(5'h00, 0);
			rd(5'h00, 1 << i);
			wr(5'h04, 1 << i);
			repeat (2) @(posedge clk);
			`CHK("irq", 1'b1, irq)
			wr(5'h00, 1 << i);
			repeat (2) @(posedge clk);
			`CHK("irq cleared", 1'b0, irq)
		end
		$display("interrupts done");
		wr(5'h08, 32'h7);
		repeat (3) @(posedge clk);
		`CHK("mgmt pins", 3'b111, {mgmt_data_o, mgmt_data_oe, mgmt_clk})
		rd(5'h08, 34'hF);
		for (k = 0; k < 6; k++) begin
			hi = $random(seed) & 5;
			wr(5'h08, hi);
			repeat (4) @(posedge clk);
			rd(5'h08, {30'h0, mgmt_data_i, hi[2:0]});
		end
		$display("management port done");
		for (i = 0; i < 5; i++) begin
			wr(5'h14, lf[i]);
			frame(fn[i], lm[i]);
		end
		`CHK("queues drained", 0, bq.size() + rq.size())
		$display("receive done");
		complete_run;
	end
endmodule // ether_mac_config_regs_test
